// ==== core/mxb_pkg.sv ====
// Package of constants for the external bus port of the microcomputer
package mxb_pkg;

  // ----------------------------------------------------------------
  // Machine cycle layout
  // ----------------------------------------------------------------
  localparam int unsigned CYC_STATES   = 15;
  localparam logic [3:0]  ST_ALE_ON    = 4'h0;
  localparam logic [3:0]  ST_ALE_OFF   = 4'h3;
  localparam logic [3:0]  ST_ADDR_OFF  = 4'h4;
  localparam logic [3:0]  ST_STB_ON    = 4'h6;
  localparam logic [3:0]  ST_STB_OFF   = 4'hc;
  localparam logic [3:0]  ST_SAMPLE    = 4'hb;
  localparam logic [3:0]  ST_LAST      = 4'he;

  // ----------------------------------------------------------------
  // Reset values and internal ROM limit
  // ----------------------------------------------------------------
  localparam logic [7:0]  PORT_RST     = 8'hff;
  localparam logic [11:0] PC_RST       = 12'h000;
  localparam int unsigned INT_ROM_LIM  = 2048;

  // ----------------------------------------------------------------
  // Bus operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MXB_OP_NONE,
    MXB_OP_FETCH,
    MXB_OP_RD,
    MXB_OP_WR,
    MXB_OP_EXP
  } mxb_op_t;

endpackage

// ==== core/mxb_sync.sv ====
// Two-stage synchroniser bank for pin inputs
`timescale 1ns/100ps
module mxb_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // mxb_sync

// ==== core/mxb_port.sv ====
// External bus, expander, port and pin control of the microcomputer
// Operation
// - One address strobe every machine cycle
// - Data bus carries traffic both ways
// - Outgoing bus data held in latch
// - Fetch drives low PC, reads code
// - Port two low nibble carries PC high
// - Code strobe gates program memory in
// - Data address first, then read/write strobe
// - Read strobe on ext move, bus input
// - Write strobe on ext move, bus output
// - Forced external access sends fetches outside
// - Port two nibble forms expander bus
// - Test pin zero outputs clock when enabled
// - Event pin edges feed counter once started
// - Interrupt pin requests and is testable
// - Single step stops after each instruction
// - Reset initialises ports and bus controls
`timescale 1ns/100ps
module mxb_port
  import mxb_pkg::*;
#(
  parameter int unsigned PC_W = 12
) (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  // core side
  input  wire logic [PC_W-1:0] pc_i,
  input  wire logic            op_valid_i,
  input  mxb_op_t              op_i,
  input  wire logic [7:0]      op_addr_i,
  input  wire logic [7:0]      op_wdata_i,
  input  wire logic [3:0]      exp_ctl_i,
  input  wire logic            port_wr_i,
  input  wire logic            port_sel_i,
  input  wire logic [7:0]      port_wdata_i,
  input  wire logic            clock_out_enable_cmd_i,
  input  wire logic            counter_begin_cmd_i,
  input  wire logic            counter_stop_cmd_i,
  input  wire logic            instr_end_i,
  output logic                 cycle_end_o,
  output logic                 fetch_ext_o,
  output logic                 op_done_o,
  output logic [7:0]           rdata_o,
  output logic                 count_event_o,
  output logic                 irq_req_o,
  output logic                 jump_irq_low_op_o,
  output logic                 test0_level_o,
  output logic                 stalled_o,
  output logic [7:0]           port_one_in_o,
  output logic [7:0]           port_two_in_o,
  // pins
  input  wire logic            ext_mem_force_i,
  input  wire logic            single_step_n_i,
  input  wire logic            irq_n_i,
  input  wire logic            event_count_pin_i,
  input  wire logic            clock_out_test_pin_i,
  output logic                 clock_out_test_pin_o,
  output logic                 clock_out_test_pin_oe_n_o,
  input  wire logic [7:0]      data_bus_i,
  output logic [7:0]           data_bus_o,
  output logic                 data_bus_oe_n_o,
  input  wire logic [7:0]      port_one_i,
  output logic [7:0]           port_one_o,
  input  wire logic [7:0]      port_two_i,
  output logic [7:0]           port_two_o,
  output logic                 ale_o,
  output logic                 code_fetch_strobe_n_o,
  output logic                 rd_n_o,
  output logic                 wr_n_o,
  output logic                 exp_strobe_n_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [20:0] pins_s;
  logic        step_s, irq_s, t1_s, t0_s, force_s;
  logic [7:0]  bus_s, p1_s;
  logic [3:0]  p2lo_s;

  mxb_sync #(.W(21)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       ({ext_mem_force_i, ~single_step_n_i, ~irq_n_i, event_count_pin_i,
                 clock_out_test_pin_i, data_bus_i, port_one_i}),
    .q_o       (pins_s)
  );
  assign {force_s, step_s, irq_s, t1_s, t0_s, bus_s, p1_s} = pins_s;

  logic [7:0] p2_s;
  mxb_sync #(.W(8)) u_sync2 (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (port_two_i),
    .q_o       (p2_s)
  );
  assign p2lo_s = p2_s[3:0];

  // ----------------------------------------------------------------
  // Machine cycle sequencer
  // ----------------------------------------------------------------
  logic [3:0] state_q;
  logic       stop_q;
  logic       cyc_last;

  assign cyc_last    = (state_q == ST_LAST);
  assign cycle_end_o = cyc_last & ~stop_q;
  assign stalled_o   = stop_q;

  // Sequencer halts only at cycle start so the strobe marks the stop
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_q <= '0;
    else if (stop_q)
      state_q <= ST_ALE_ON;
    else if (cyc_last)
      state_q <= '0;
    else
      state_q <= state_q + 4'h1;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      stop_q <= 1'b0;
    else if (cyc_last && instr_end_i && step_s)
      stop_q <= 1'b1;
    else if (!step_s)
      stop_q <= 1'b0;
  end

  // One strobe per cycle, held high while parked in single step
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ale_o <= 1'b0;
    else
      ale_o <= stop_q | ((state_q >= ST_ALE_ON) && (state_q < ST_ALE_OFF) && !cyc_last);
  end

  // ----------------------------------------------------------------
  // Operation capture
  // ----------------------------------------------------------------
  mxb_op_t    cur_op_q;
  logic [7:0] out_latch_q;
  logic [7:0] addr_q;
  logic [3:0] pc_hi_q;
  logic       ext_fetch;

  assign ext_fetch   = force_s || (pc_i >= PC_W'(INT_ROM_LIM));
  assign fetch_ext_o = ext_fetch;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cur_op_q    <= MXB_OP_NONE;
      addr_q      <= '0;
      pc_hi_q     <= PC_RST[11:8];
      out_latch_q <= '0;
    end
    else if (cyc_last && !stop_q)
    begin
      if (op_valid_i)
      begin
        cur_op_q <= op_i;
        addr_q   <= (op_i == MXB_OP_FETCH) ? pc_i[7:0] : op_addr_i;
        pc_hi_q  <= pc_i[11:8];
        if (op_i == MXB_OP_WR || op_i == MXB_OP_EXP)
          out_latch_q <= op_wdata_i;
        if (op_i == MXB_OP_FETCH && !ext_fetch)
          cur_op_q <= MXB_OP_NONE;
      end
      else
        cur_op_q <= MXB_OP_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Strobes and bus drive
  // ----------------------------------------------------------------
  logic in_stb, in_addr;
  assign in_stb  = (state_q >= ST_STB_ON) && (state_q < ST_STB_OFF) && !stop_q;
  assign in_addr = (state_q < ST_ADDR_OFF) && !stop_q;

  // Only one strobe selected per op, so no overlap is possible
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      code_fetch_strobe_n_o <= 1'b1;
      rd_n_o                <= 1'b1;
      wr_n_o                <= 1'b1;
      exp_strobe_n_o        <= 1'b1;
    end
    else
    begin
      code_fetch_strobe_n_o <= ~(in_stb && cur_op_q == MXB_OP_FETCH);
      rd_n_o                <= ~(in_stb && cur_op_q == MXB_OP_RD);
      wr_n_o                <= ~(in_stb && cur_op_q == MXB_OP_WR);
      exp_strobe_n_o        <= ~(in_stb && cur_op_q == MXB_OP_EXP);
    end
  end

  // Bus: address phase, then write data; released for reads
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_bus_o      <= '0;
      data_bus_oe_n_o <= 1'b1;
    end
    else if (in_addr && cur_op_q != MXB_OP_NONE && cur_op_q != MXB_OP_EXP)
    begin
      data_bus_o      <= addr_q;
      data_bus_oe_n_o <= 1'b0;
    end
    else if (!in_addr && cur_op_q == MXB_OP_WR && state_q <= ST_STB_OFF)
    begin
      data_bus_o      <= out_latch_q;
      data_bus_oe_n_o <= 1'b0;
    end
    else
      data_bus_oe_n_o <= 1'b1;
  end

  // Read data captured before strobe rises
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o   <= '0;
      op_done_o <= 1'b0;
    end
    else
    begin
      op_done_o <= (state_q == ST_SAMPLE) && !stop_q && cur_op_q != MXB_OP_NONE;
      if ((state_q == ST_SAMPLE) && !stop_q)
      begin
        if (cur_op_q == MXB_OP_FETCH || cur_op_q == MXB_OP_RD)
          rdata_o <= bus_s;
        else if (cur_op_q == MXB_OP_EXP)
          rdata_o <= {4'h0, p2lo_s};
      end
    end
  end

  // ----------------------------------------------------------------
  // Quasi-bidirectional ports
  // ----------------------------------------------------------------
  logic [7:0] p1_q, p2_q;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      p1_q <= PORT_RST;
      p2_q <= PORT_RST;
    end
    else if (port_wr_i)
    begin
      if (port_sel_i)
        p2_q <= port_wdata_i;
      else
        p1_q <= port_wdata_i;
    end
  end

  // Weak-high lines read pin AND latch, hence the ones-first need
  assign port_one_o    = p1_q;
  assign port_one_in_o = p1_s & p1_q;
  assign port_two_in_o = p2_s & p2_q;

  // Low nibble borrowed for PC high bits and expander traffic
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      port_two_o <= PORT_RST;
    else if (cur_op_q == MXB_OP_FETCH && !stop_q)
      port_two_o <= {p2_q[7:4], pc_hi_q};
    else if (cur_op_q == MXB_OP_EXP && !stop_q)
      port_two_o <= {p2_q[7:4], in_stb ? out_latch_q[3:0] : exp_ctl_i};
    else
      port_two_o <= p2_q;
  end

  // ----------------------------------------------------------------
  // Test pins and interrupt
  // ----------------------------------------------------------------
  logic clk_en_q, cnt_en_q, t1_prev_q;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      clk_en_q <= 1'b0;
    else if (clock_out_enable_cmd_i)
      clk_en_q <= 1'b1;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      clock_out_test_pin_o <= 1'b0;
    else
      clock_out_test_pin_o <= clk_en_q & ~clock_out_test_pin_o;
  end
  assign clock_out_test_pin_oe_n_o = ~clk_en_q;
  assign test0_level_o             = t0_s;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_en_q  <= 1'b0;
      t1_prev_q <= 1'b0;
    end
    else
    begin
      t1_prev_q <= t1_s;
      if (counter_begin_cmd_i)
        cnt_en_q <= 1'b1;
      else if (counter_stop_cmd_i)
        cnt_en_q <= 1'b0;
    end
  end
  // Falling edge counts; a level held low counts once
  assign count_event_o = cnt_en_q & t1_prev_q & ~t1_s;

  assign irq_req_o         = irq_s;
  assign jump_irq_low_op_o = irq_s;

endmodule // mxb_port

// ==== test/mxb_port_props.sv ====
// Bus timing checker for the external bus port
`timescale 1ns/100ps
module mxb_port_props
  import mxb_pkg::*;
#(
  parameter int unsigned PC_W = 12
) (
  input wire logic            ref_clk_i,
  input wire logic            rst_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic            op_valid_i,
  input mxb_op_t              op_i,
  input wire logic [7:0]      op_addr_i,
  input wire logic            instr_end_i,
  input wire logic            cycle_end_o,
  input wire logic            fetch_ext_o,
  input wire logic            op_done_o,
  input wire logic            stalled_o,
  input wire logic [7:0]      data_bus_o,
  input wire logic            data_bus_oe_n_o,
  input wire logic [7:0]      port_two_o,
  input wire logic            ale_o,
  input wire logic            code_fetch_strobe_n_o,
  input wire logic            rd_n_o,
  input wire logic            wr_n_o,
  input wire logic            exp_strobe_n_o
);
  // ----
  // Taken requests
  // ----
  logic tk_rd, tk_wr, tk_fx;
  assign tk_rd = cycle_end_o && op_valid_i && (op_i == MXB_OP_RD);
  assign tk_wr = cycle_end_o && op_valid_i && (op_i == MXB_OP_WR);
  assign tk_fx = cycle_end_o && op_valid_i && (op_i == MXB_OP_FETCH);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_ale_once;
    cycle_end_o && !instr_end_i |=> !ale_o ##1 ale_o[*3] ##1 !ale_o;
  endproperty
  a_ale_once: assert property (p_ale_once) else $error("ale shape");
  property p_period;
    cycle_end_o |-> ##15 (cycle_end_o || stalled_o);
  endproperty
  a_period: assert property (p_period) else $error("cycle length");
  property p_cf_len;
    $fell(code_fetch_strobe_n_o) |=> !code_fetch_strobe_n_o[*5] ##1 code_fetch_strobe_n_o;
  endproperty
  a_cf_len: assert property (p_cf_len) else $error("fetch strobe width");
  property p_rd_at;
    tk_rd |-> ##8 !rd_n_o ##6 rd_n_o;
  endproperty
  a_rd_at: assert property (p_rd_at) else $error("read strobe");
  property p_wr_at;
    tk_wr |-> ##8 !wr_n_o;
  endproperty
  a_wr_at: assert property (p_wr_at) else $error("write strobe");
  property p_wr_hold;
    !wr_n_o |-> !data_bus_oe_n_o && $stable(data_bus_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved");
  property p_excl;
    $onehot0({!code_fetch_strobe_n_o, !rd_n_o, !wr_n_o, !exp_strobe_n_o});
  endproperty
  a_excl: assert property (p_excl) else $error("strobes overlap");
  property p_fx_addr;
    tk_fx && fetch_ext_o |-> ##3 !data_bus_oe_n_o && data_bus_o == pc_i[7:0]
      && port_two_o[3:0] == pc_i[11:8];
  endproperty
  a_fx_addr: assert property (p_fx_addr) else $error("fetch address");
  property p_rd_addr;
    tk_rd |-> ##3 !data_bus_oe_n_o && data_bus_o == op_addr_i;
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("data address");
  property p_int;
    tk_fx && !fetch_ext_o |-> ##8 code_fetch_strobe_n_o[*6];
  endproperty
  a_int: assert property (p_int) else $error("internal fetch on bus");
  property p_done;
    tk_rd |-> ##[12:13] op_done_o;
  endproperty
  a_done: assert property (p_done) else $error("no read answer");
  property p_stall;
    stalled_o |-> !cycle_end_o ##1 ale_o;
  endproperty
  a_stall: assert property (p_stall) else $error("stall marker");
  c_fetch: cover property (tk_fx && fetch_ext_o);
  c_wr: cover property (tk_wr);
  c_stall: cover property (stalled_o);
endmodule // mxb_port_props

bind mxb_port mxb_port_props #(.PC_W(PC_W)) i_props (.*);

// ==== test/mxb_mem_model.sv ====
// Program memory, data memory and expander model on the bus
`timescale 1ns/100ps
module mxb_mem_model (
  input  wire logic       ref_clk_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] data_bus_o,
  input  wire logic       data_bus_oe_n_o,
  input  wire logic [7:0] port_two_o,
  input  wire logic       ale_o,
  input  wire logic       code_fetch_strobe_n_o,
  input  wire logic       rd_n_o,
  input  wire logic       wr_n_o,
  input  wire logic       exp_strobe_n_o,
  output logic      [7:0] data_bus_i,
  output logic      [3:0] exp_ctl_q,
  output logic      [3:0] exp_dat_q
);
  // ----
  // Storage and drive
  // ----
  logic [7:0] mem [256];
  logic [7:0] adr, last_q;
  logic [3:0] pt_q;
  logic       rq_q, fch_q, ex_q, act;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  assign act = slow_i ? rq_q : !(code_fetch_strobe_n_o && rd_n_o);
  always @(posedge ref_clk_i)
  begin
    if (ale_o && !data_bus_oe_n_o) adr <= data_bus_o;
    rq_q <= !(code_fetch_strobe_n_o && rd_n_o);
    fch_q <= !code_fetch_strobe_n_o;
    if (!wr_n_o) mem[adr] <= data_bus_o;
    pt_q <= port_two_o[3:0];
    ex_q <= exp_strobe_n_o;
    if (ex_q && !exp_strobe_n_o) exp_ctl_q <= pt_q;
    if (!exp_strobe_n_o) exp_dat_q <= port_two_o[3:0];
    last_q <= data_bus_i;
  end
  // Released bus shows a moving pattern, not a held value
  always_comb
    if (!data_bus_oe_n_o) data_bus_i = data_bus_o;
    else if (act) data_bus_i = (fch_q || !code_fetch_strobe_n_o) ? adr ^ 8'ha5 : mem[adr];
    else data_bus_i = ~last_q;
endmodule // mxb_mem_model

// ==== test/tb_mxb_port.sv ====
// Self-checking testbench of the external bus port
`timescale 1ns/100ps
module tb_mxb_port;
  import mxb_pkg::*;
  // ----
  // Signals
  // ----
  logic ref_clk_i = 0, rst_i = 1, op_valid_i = 0, port_wr_i = 0, port_sel_i = 0;
  logic clock_out_enable_cmd_i = 0, counter_begin_cmd_i = 0, counter_stop_cmd_i = 0;
  logic instr_end_i = 0, ext_mem_force_i = 1, single_step_n_i = 1, irq_n_i = 1;
  logic event_count_pin_i = 1, t0_drv = 1, slow_i = 0, clock_out_test_pin_i, v;
  logic [11:0] pc_i = 0;
  logic [7:0] op_addr_i = 0, op_wdata_i = 0, port_wdata_i = 0, p1_drv = 8'hff;
  logic [3:0] exp_ctl_i = 0, exp_ctl_q, exp_dat_q;
  mxb_op_t op_i = MXB_OP_NONE;
  logic cycle_end_o, fetch_ext_o, op_done_o, count_event_o, irq_req_o, jump_irq_low_op_o;
  logic test0_level_o, stalled_o, clock_out_test_pin_o, clock_out_test_pin_oe_n_o;
  logic data_bus_oe_n_o, ale_o, code_fetch_strobe_n_o, rd_n_o, wr_n_o, exp_strobe_n_o;
  logic [7:0] rdata_o, port_one_in_o, port_two_in_o, data_bus_i, data_bus_o;
  logic [7:0] port_one_o, port_one_i, port_two_o, port_two_i;
  int err_count = 0, cmp_count = 0, n_ev = 0, n_cf = 0, n, k;
  always #25 ref_clk_i = ~ref_clk_i;
  assign clock_out_test_pin_i = clock_out_test_pin_oe_n_o ? t0_drv : clock_out_test_pin_o;
  assign port_one_i = port_one_o & p1_drv;
  assign port_two_i = port_two_o;
  mxb_port i_dut (.*);
  mxb_mem_model i_mem (.*);
  always @(posedge ref_clk_i)
  begin
    if (count_event_o === 1'b1) n_ev++;
    if ($fell(code_fetch_strobe_n_o)) n_cf++;
  end
  task automatic chk(input logic [7:0] g, e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask
  // Request held until the cycle end edge takes it
  task automatic do_op(input mxb_op_t o, input logic [11:0] p, input logic [7:0] a, d);
    logic dn;
    // Internal fetch is refused on the bus, so no done pulse
    dn = (o != MXB_OP_FETCH) || ext_mem_force_i || (p >= 12'(INT_ROM_LIM));
    @(posedge ref_clk_i);
    op_i <= o;
    pc_i <= p;
    op_addr_i <= a;
    op_wdata_i <= d;
    op_valid_i <= 1;
    do @(negedge ref_clk_i); while (cycle_end_o !== 1'b1);
    @(posedge ref_clk_i);
    op_valid_i <= 0;
    for (k = 0; k < 20 && op_done_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk(k < 20, dn, "op done");
    @(posedge ref_clk_i);
  endtask
  task automatic pwr(input logic s, input logic [7:0] d);
    @(posedge ref_clk_i);
    port_wr_i <= 1;
    port_sel_i <= s;
    port_wdata_i <= d;
    @(posedge ref_clk_i);
    port_wr_i <= 0;
    cyc(4);
  endtask
  task automatic tog(input int c);
    repeat (c)
    begin
      @(posedge ref_clk_i);
      event_count_pin_i <= 0;
      cyc(3);
      event_count_pin_i <= 1;
      cyc(3);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    chk({ale_o, data_bus_oe_n_o, clock_out_test_pin_oe_n_o, code_fetch_strobe_n_o,
         rd_n_o, wr_n_o, exp_strobe_n_o}, 8'h3f, "reset pins");
    chk(port_one_o & port_two_o, PORT_RST, "reset ports");
  endtask
  task automatic t_fetch();
    do_op(MXB_OP_FETCH, 12'h3c5, 0, 0);
    chk(rdata_o, 8'h60, "forced fetch");
    ext_mem_force_i <= 0;
    cyc(2);
    n = n_cf;
    do_op(MXB_OP_FETCH, 12'h7ff, 0, 0);
    chk(n_cf - n, 0, "internal fetch");
    do_op(MXB_OP_FETCH, 12'h800, 0, 0);
    chk(rdata_o, 8'ha5, "fetch above rom");
    chk(n_cf - n, 1, "one code strobe");
    ext_mem_force_i <= 1;
  endtask
  task automatic t_rdwr();
    do_op(MXB_OP_WR, 0, 8'h33, 8'h96);
    do_op(MXB_OP_RD, 0, 8'h33, 0);
    chk(rdata_o, 8'h96, "write then read");
    slow_i <= 1;
    do_op(MXB_OP_RD, 0, 8'h44, 0);
    chk(rdata_o, 8'h1e, "slow read");
    slow_i <= 0;
  endtask
  task automatic t_exp();
    exp_ctl_i <= 4'h2;
    do_op(MXB_OP_EXP, 0, 0, 8'h07);
    chk({exp_ctl_q, exp_dat_q}, 8'h27, "expander");
  endtask
  task automatic t_port();
    p1_drv <= 8'hf3;
    cyc(4);
    chk(port_one_in_o, 8'hf3, "input after reset");
    pwr(0, 8'h0f);
    chk(port_one_in_o, 8'h03, "latched low");
    pwr(0, 8'hff);
    chk(port_one_in_o, 8'hf3, "ones restored");
    pwr(1, 8'hf0);
    chk(port_two_o, 8'hf0, "port two latch");
    chk(port_two_in_o, 8'hf0, "port two input");
    pwr(1, 8'hff);
  endtask
  task automatic t_pins();
    irq_n_i <= 0;
    t0_drv <= 0;
    cyc(4);
    chk({irq_req_o, jump_irq_low_op_o, test0_level_o}, 3'b110, "irq low");
    irq_n_i <= 1;
    cyc(4);
    chk({irq_req_o, jump_irq_low_op_o}, 0, "irq high");
    n = n_ev;
    tog(2);
    counter_begin_cmd_i <= 1;
    cyc(1);
    counter_begin_cmd_i <= 0;
    tog(3);
    counter_stop_cmd_i <= 1;
    cyc(1);
    counter_stop_cmd_i <= 0;
    tog(1);
    chk(8'(n_ev - n), 3, "event count");
    clock_out_enable_cmd_i <= 1;
    cyc(1);
    clock_out_enable_cmd_i <= 0;
    cyc(3);
    v = clock_out_test_pin_o;
    chk(clock_out_test_pin_oe_n_o, 0, "clock out drives");
    cyc(1);
    chk(clock_out_test_pin_o, !v, "clock toggles");
  endtask
  task automatic t_step();
    single_step_n_i <= 0;
    instr_end_i <= 1;
    for (k = 0; k < 40 && stalled_o !== 1'b1; k++) @(negedge ref_clk_i);
    cyc(20);
    chk({stalled_o, ale_o}, 3, "parked");
    single_step_n_i <= 1;
    instr_end_i <= 0;
    for (k = 0; k < 30 && cycle_end_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk({k < 30, stalled_o}, 2, "resumed");
  endtask
  initial
  begin
    cyc(10);
    t_reset();
    cyc(10);
    rst_i <= 0;
    t_fetch();
    t_rdwr();
    t_exp();
    t_port();
    t_pins();
    cyc(1);
    t_step();
    wrap_up();
  end
  initial
  begin
    #500000;
    err_count++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    wrap_up();
  end
endmodule // tb_mxb_port
